// >>> rtl/lcfr_lock_current_fault_response.sv
// Purpose: lock detection by current limit and the fault reaction it drives
// Assumes: all inputs synchronous to sys_clk; phaseSense in steps of 0.1 V
// Notes:   register port is a plain write strobe with a read-back bus
//
// What this block does
// - The sensed phase voltage is compared with the threshold code times 0.1 V, code 0 never trips.
// - The lock response select is a 4-bit read/write field at bits 18 to 15, zero after reset.
// - Codes 0 to 3 latch the fault with fault_out_n low, code 0 tristates and code 1 recirculates.
// - Codes 2 and 6 turn on all three high-side switches while the response lasts.
// - Codes 3 and 7 turn on all three low-side switches while the response lasts.
// - Codes 4 to 7 apply their stage state and resume by themselves after the lock retry interval.
// - Code 8 only reports the lock and leaves the output stage alone.
// - Codes 9 to 15 switch lock detection off with no report and no action.
// - The filter time field at bits 14 to 11 picks 1 ms up to 50 s.
// - The field at bits 10 to 8 holds how many PWM cycles the cycle limit waits before retry.
// - The lock retry select picks 100 ms up to 10000 ms.
// - In counted cycle-limit recovery the stage recirculates and resumes after the set PWM cycles.
`timescale 1ns/100ps
`default_nettype none
module lcfr_lock_current_fault_response #(
   parameter int CYCLES_PER_MS = lcfr_pkg::CYCLES_PER_MS
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // register port
   input wire logic cfgWrite,
   input wire logic [31:0] cfgWdata,
   output logic [31:0] cfgRdata,
   // sensing and events
   input wire logic [7:0] phaseSense,
   input wire logic cycleLimitHit,
   input wire logic pwmCycleStart,
   input wire logic faultClear,
   // power stage and fault
   output lcfr_pkg::lcfr_stage_type stageMode,
   output logic [2:0] highSideOn,
   output logic [2:0] lowSideOn,
   output logic fault_out_n,
   output logic lockReported
);
   // ----------------------------------------
   // time tables
   // ----------------------------------------
   // filter and retry times in ms, turned to cycles with the tick parameter
   function automatic logic [35:0] msToCycles(input logic [15:0] ms);
      msToCycles = 36'(ms) * 36'(CYCLES_PER_MS);
   endfunction

   // ----------------------------------------
   // configuration register
   // ----------------------------------------
   logic [31:0] cfg_reg;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_reg <= lcfr_pkg::CFG_RESET;
      end else if (cfgWrite) begin
         cfg_reg <= cfgWdata;
      end
   end
   assign cfgRdata = cfg_reg;

   logic [3:0] lockThr;
   logic [3:0] lockMode;
   logic [3:0] filterSel;
   logic [2:0] cbcRetry;
   logic [2:0] retrySel;
   logic [3:0] cbcMode;
   assign lockThr = cfg_reg[lcfr_pkg::LOCK_THR_LSB +: 4];
   assign lockMode = cfg_reg[lcfr_pkg::LOCK_MODE_LSB +: 4];
   assign filterSel = cfg_reg[lcfr_pkg::LOCK_DEG_LSB +: 4];
   assign cbcRetry = cfg_reg[lcfr_pkg::CBC_RETRY_LSB +: 3];
   assign retrySel = cfg_reg[lcfr_pkg::LOCK_RETRY_LSB +: 3];
   assign cbcMode = cfg_reg[lcfr_pkg::CBC_MODE_LSB +: 4];

   // ----------------------------------------
   // threshold and filter
   // ----------------------------------------
   logic overNow;
   logic detectOn;
   logic counting;
   logic lockDetect;
   logic [35:0] degCnt_reg;
   logic [35:0] retryCnt_reg;
   lcfr_pkg::lcfr_lock_type lockState_reg;

   // code 0 has no threshold, so it never trips
   assign overNow = (lockThr != 4'h0) && (phaseSense > {4'h0, lockThr});
   assign detectOn = (lockMode <= lcfr_pkg::MODE_REPORT);
   assign counting = overNow && detectOn && (lockState_reg == lcfr_pkg::LOCK_NORMAL);
   assign lockDetect = counting &&
      (degCnt_reg == msToCycles(lcfr_pkg::FILTER_MS[filterSel]) - 36'h1);

   // any drop of the condition restarts the whole filter time
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         degCnt_reg <= '0;
      end else if (!counting || lockDetect) begin
         degCnt_reg <= '0;
      end else begin
         degCnt_reg <= degCnt_reg + 36'h1;
      end
   end

   // ----------------------------------------
   // lock response state
   // ----------------------------------------
   // the code is captured at detection so a rewrite cannot change a live response
   logic [3:0] action_reg;
   logic retryDone;
   assign retryDone = (retryCnt_reg == msToCycles(lcfr_pkg::RETRY_MS[retrySel]) - 36'h1);

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         lockState_reg <= lcfr_pkg::LOCK_NORMAL;
         action_reg <= 4'h0;
      end else begin
         case (lockState_reg)
            lcfr_pkg::LOCK_NORMAL: begin
               if (lockDetect && lockMode <= lcfr_pkg::MODE_LATCH_LAST) begin
                  lockState_reg <= lcfr_pkg::LOCK_LATCHED;
                  action_reg <= lockMode;
               end else if (lockDetect && lockMode <= lcfr_pkg::MODE_RETRY_LAST) begin
                  lockState_reg <= lcfr_pkg::LOCK_RETRY;
                  action_reg <= lockMode;
               end
            end
            lcfr_pkg::LOCK_LATCHED: begin
               if (faultClear) begin
                  lockState_reg <= lcfr_pkg::LOCK_NORMAL;
               end
            end
            lcfr_pkg::LOCK_RETRY: begin
               if (retryDone) begin
                  lockState_reg <= lcfr_pkg::LOCK_NORMAL;
               end
            end
            default: lockState_reg <= lcfr_pkg::LOCK_NORMAL;
         endcase
      end
   end

   // retry interval timer
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         retryCnt_reg <= '0;
      end else if (lockState_reg != lcfr_pkg::LOCK_RETRY || retryDone) begin
         retryCnt_reg <= '0;
      end else begin
         retryCnt_reg <= retryCnt_reg + 36'h1;
      end
   end

   // report flag: a new detection wins over a clear in the same cycle
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         lockReported <= 1'b0;
      end else if (lockDetect && lockMode == lcfr_pkg::MODE_REPORT) begin
         lockReported <= 1'b1;
      end else if (faultClear) begin
         lockReported <= 1'b0;
      end
   end

   // ----------------------------------------
   // cycle-by-cycle limit retry
   // ----------------------------------------
   lcfr_pkg::lcfr_cbc_type cbcState_reg;
   logic [2:0] cbcCnt_reg;
   logic cbcFault_reg;
   logic cbcCounted;
   assign cbcCounted = (cbcMode == lcfr_pkg::CBC_COUNT_FAULT) ||
                       (cbcMode == lcfr_pkg::CBC_COUNT_QUIET);

   // next-cycle modes behave as a count of zero
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cbcState_reg <= lcfr_pkg::CBC_IDLE;
         cbcCnt_reg <= 3'h0;
         cbcFault_reg <= 1'b0;
      end else begin
         case (cbcState_reg)
            lcfr_pkg::CBC_IDLE: begin
               if (cycleLimitHit && (cbcCounted || cbcMode == lcfr_pkg::CBC_NEXT_FAULT ||
                                     cbcMode == lcfr_pkg::CBC_NEXT_QUIET)) begin
                  cbcState_reg <= lcfr_pkg::CBC_WAIT;
                  cbcCnt_reg <= cbcCounted ? cbcRetry : 3'h0;
                  cbcFault_reg <= (cbcMode == lcfr_pkg::CBC_COUNT_FAULT) ||
                                  (cbcMode == lcfr_pkg::CBC_NEXT_FAULT);
               end
            end
            lcfr_pkg::CBC_WAIT: begin
               if (pwmCycleStart && cbcCnt_reg == 3'h0) begin
                  cbcState_reg <= lcfr_pkg::CBC_IDLE;
                  cbcFault_reg <= 1'b0;
               end else if (pwmCycleStart) begin
                  cbcCnt_reg <= cbcCnt_reg - 3'h1;
               end
            end
            default: cbcState_reg <= lcfr_pkg::CBC_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // output stage and fault pin
   // ----------------------------------------
   // lock response outranks the cycle limit, which only recirculates
   lcfr_pkg::lcfr_stage_type stageNext;
   always_comb begin
      stageNext = lcfr_pkg::STAGE_DRIVE;
      if (lockState_reg != lcfr_pkg::LOCK_NORMAL) begin
         case (action_reg[1:0])
            2'h0: stageNext = lcfr_pkg::STAGE_TRISTATE;
            2'h1: stageNext = lcfr_pkg::STAGE_RECIRC;
            2'h2: stageNext = lcfr_pkg::STAGE_HS_BRAKE;
            default: stageNext = lcfr_pkg::STAGE_LS_BRAKE;
         endcase
      end else if (cbcState_reg == lcfr_pkg::CBC_WAIT) begin
         stageNext = lcfr_pkg::STAGE_RECIRC;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         stageMode <= lcfr_pkg::STAGE_DRIVE;
         highSideOn <= 3'h0;
         lowSideOn <= 3'h0;
         fault_out_n <= 1'b1;
      end else begin
         stageMode <= stageNext;
         highSideOn <= {3{stageNext == lcfr_pkg::STAGE_HS_BRAKE}};
         lowSideOn <= {3{stageNext == lcfr_pkg::STAGE_LS_BRAKE}};
         fault_out_n <= !((lockState_reg != lcfr_pkg::LOCK_NORMAL) || lockReported ||
                          cbcFault_reg);
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   cfg_store_a: assert property (cfgWrite |=> cfgRdata == $past(cfgWdata))
      else $error("config word not stored");
   thr_zero_a: assert property (lockThr == 4'h0 |=> degCnt_reg == '0)
      else $error("filter ran with threshold code zero");
   filter_restart_a: assert property (!overNow |=> degCnt_reg == '0)
      else $error("filter did not restart on drop");
   disabled_a: assert property (lockMode > lcfr_pkg::MODE_REPORT |=> degCnt_reg == '0)
      else $error("detection ran while disabled");
   latch_fault_a: assert property (lockDetect && lockMode <= lcfr_pkg::MODE_LATCH_LAST
      |=> lockState_reg == lcfr_pkg::LOCK_LATCHED ##1 !fault_out_n)
      else $error("latched fault not shown");
   latch_hold_a: assert property (lockState_reg == lcfr_pkg::LOCK_LATCHED && !faultClear
      |=> lockState_reg == lcfr_pkg::LOCK_LATCHED)
      else $error("latched fault dropped without clear");
   hs_brake_a: assert property (lockState_reg != lcfr_pkg::LOCK_NORMAL && action_reg[1:0] == 2'h2
      |=> highSideOn == 3'h7 && lowSideOn == 3'h0)
      else $error("high-side brake not applied");
   ls_brake_a: assert property (lockState_reg != lcfr_pkg::LOCK_NORMAL && action_reg[1:0] == 2'h3
      |=> lowSideOn == 3'h7 && highSideOn == 3'h0)
      else $error("low-side brake not applied");
   retry_resume_a: assert property (lockState_reg == lcfr_pkg::LOCK_RETRY && retryDone
      |=> lockState_reg == lcfr_pkg::LOCK_NORMAL)
      else $error("no resume after retry interval");
   report_only_a: assert property (lockDetect && lockMode == lcfr_pkg::MODE_REPORT
      |=> lockReported && lockState_reg == lcfr_pkg::LOCK_NORMAL)
      else $error("report-only mode acted");
   cbc_count_a: assert property (cbcState_reg == lcfr_pkg::CBC_WAIT && pwmCycleStart &&
      cbcCnt_reg != 3'h0 |=> cbcCnt_reg == $past(cbcCnt_reg) - 3'h1 &&
      cbcState_reg == lcfr_pkg::CBC_WAIT)
      else $error("cycle limit count wrong");
   cbc_recirc_a: assert property (cbcState_reg == lcfr_pkg::CBC_WAIT &&
      lockState_reg == lcfr_pkg::LOCK_NORMAL |=> stageMode == lcfr_pkg::STAGE_RECIRC)
      else $error("no recirculation during cycle limit");

   latch_seen_c: cover property (lockState_reg == lcfr_pkg::LOCK_LATCHED ##1 faultClear);
   retry_seen_c: cover property (lockState_reg == lcfr_pkg::LOCK_RETRY && retryDone);
   report_seen_c: cover property (lockReported);
   cbc_seen_c: cover property (cbcState_reg == lcfr_pkg::CBC_WAIT && pwmCycleStart);
endmodule // lcfr_lock_current_fault_response
`default_nettype wire

// >>> rtl/lcfr_pkg.sv
// Purpose: constants and types for the lock current fault response block
// Assumes: 200 MHz system clock
// Notes:   all times are kept in milliseconds and turned into cycles in the block
package lcfr_pkg;
   // ----------------------------------------
   // clock and time base
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int MS_NS = 1000000;
   localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;

   // ----------------------------------------
   // configuration register layout
   // ----------------------------------------
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam int CBC_MODE_LSB = 23;   // cycle_limit_response, 4 bits
   localparam int LOCK_THR_LSB = 19;   // lock current threshold, 4 bits
   localparam int LOCK_MODE_LSB = 15;  // lock response select, 4 bits
   localparam int LOCK_DEG_LSB = 11;   // lock_current_filter_time, 4 bits
   localparam int CBC_RETRY_LSB = 8;   // cycle_limit_retry_count, 3 bits
   localparam int LOCK_RETRY_LSB = 0;  // lock_retry_select, 3 bits

   // ----------------------------------------
   // response codes
   // ----------------------------------------
   localparam logic [3:0] MODE_LATCH_LAST = 4'h3;
   localparam logic [3:0] MODE_RETRY_LAST = 4'h7;
   localparam logic [3:0] MODE_REPORT = 4'h8;
   localparam logic [3:0] CBC_NEXT_FAULT = 4'h0;
   localparam logic [3:0] CBC_NEXT_QUIET = 4'h1;
   localparam logic [3:0] CBC_COUNT_FAULT = 4'h4;
   localparam logic [3:0] CBC_COUNT_QUIET = 4'h5;

   // ----------------------------------------
   // time tables in milliseconds
   // ----------------------------------------
   // lock filter time by code; the second-range steps stay in ms so one scaler serves all
   localparam logic [15:0] FILTER_MS [16] = '{16'h0001, 16'h0002, 16'h0005, 16'h000A,
      16'h0019, 16'h0032, 16'h004B, 16'h0064, 16'h00FA, 16'h01F4, 16'h03E8, 16'h09C4,
      16'h1388, 16'h2710, 16'h61A8, 16'hC350};
   // lock retry interval by code
   localparam logic [15:0] RETRY_MS [8] = '{16'h0064, 16'h01F4, 16'h03E8, 16'h07D0,
      16'h0BB8, 16'h1388, 16'h1D4C, 16'h2710};

   // ----------------------------------------
   // states and output stage modes
   // ----------------------------------------
   typedef enum logic [2:0] {
      STAGE_DRIVE, STAGE_TRISTATE, STAGE_RECIRC, STAGE_HS_BRAKE, STAGE_LS_BRAKE
   } lcfr_stage_type;
   typedef enum logic [1:0] {LOCK_NORMAL, LOCK_LATCHED, LOCK_RETRY} lcfr_lock_type;
   typedef enum logic {CBC_IDLE, CBC_WAIT} lcfr_cbc_type;
endpackage

// >>> bench/lcfr_stage_model.sv
// Purpose: power stage and motor seen from the lock current block
// Assumes: motor current collapses as soon as the stage stops driving
// Notes:   pwm period is a parameter; cycle limit hits come from the bench
`timescale 1ns/100ps
`default_nettype none
module lcfr_stage_model #(
   parameter int PWM_PERIOD = 8
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // bench controls
   input wire logic [7:0] loadLevel,
   input wire logic hitReq,
   // stage side
   input wire lcfr_pkg::lcfr_stage_type stageMode,
   output logic [7:0] phaseSense,
   output logic cycleLimitHit,
   output logic pwmCycleStart
);
   // ----------------------------------------
   // pwm period and sensed current
   // ----------------------------------------
   logic [7:0] pwmCnt_reg;
   // free-running period counter, one-cycle start pulse at zero
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pwmCnt_reg <= 8'h00;
      end else if (pwmCnt_reg == 8'(PWM_PERIOD - 1)) begin
         pwmCnt_reg <= 8'h00;
      end else begin
         pwmCnt_reg <= pwmCnt_reg + 8'h01;
      end
   end
   assign pwmCycleStart = reset_n && (pwmCnt_reg == 8'h00);
   // no current flows once the stage leaves drive, so a latched fault must hold on its own
   assign phaseSense = (stageMode == lcfr_pkg::STAGE_DRIVE) ? loadLevel : 8'h00;
   assign cycleLimitHit = hitReq;
endmodule // lcfr_stage_model
`default_nettype wire

// >>> bench/lcfr_lock_current_fault_response_bench.sv
// Purpose: self-checking bench for the lock current fault response block
// Assumes: CYCLES_PER_MS set to 2 so 1 ms is two clocks
// Notes:   inputs change at the falling edge only
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
   $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module lcfr_lock_current_fault_response_bench;
   logic sys_clk, reset_n, cfgWrite, hitReq, faultClear, cycleLimitHit, pwmCycleStart;
   logic [31:0] cfgWdata, cfgRdata;
   logic [7:0] loadLevel, phaseSense;
   logic [2:0] highSideOn, lowSideOn;
   logic fault_out_n, lockReported;
   lcfr_pkg::lcfr_stage_type stageMode;
   int error_cnt = 0;
   int comparisons = 0;
   int n, p;
   lcfr_pkg::lcfr_stage_type expStage[4] = '{lcfr_pkg::STAGE_TRISTATE,
      lcfr_pkg::STAGE_RECIRC, lcfr_pkg::STAGE_HS_BRAKE, lcfr_pkg::STAGE_LS_BRAKE};
   int retryMs[4] = '{100, 500, 1000, 2000};
   int degMs[3] = '{1, 2, 5};
   logic [3:0] cbcCode[5] = '{4'h0, 4'h4, 4'h1, 4'h5, 4'h7};
   // per cycle-limit code above: pwm starts seen while recirculating, fault pin level
   int cbcStarts[5] = '{1, 3, 1, 3, 0};
   logic cbcFaultLvl[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

   lcfr_lock_current_fault_response #(.CYCLES_PER_MS(2)) dut (.sys_clk(sys_clk),
      .reset_n(reset_n), .cfgWrite(cfgWrite), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata),
      .phaseSense(phaseSense), .cycleLimitHit(cycleLimitHit), .pwmCycleStart(pwmCycleStart),
      .faultClear(faultClear), .stageMode(stageMode), .highSideOn(highSideOn),
      .lowSideOn(lowSideOn), .fault_out_n(fault_out_n), .lockReported(lockReported));
   lcfr_stage_model #(.PWM_PERIOD(8)) stage (.sys_clk(sys_clk), .reset_n(reset_n),
      .loadLevel(loadLevel), .hitReq(hitReq), .stageMode(stageMode),
      .phaseSense(phaseSense), .cycleLimitHit(cycleLimitHit), .pwmCycleStart(pwmCycleStart));

   // ----------------------------------------
   // clock and shared tasks
   // ----------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic finish_test;
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(negedge sys_clk);
   endtask
   function automatic logic [31:0] cfg(input logic [3:0] cbc, input logic [3:0] thr,
      input logic [3:0] md, input logic [3:0] deg, input logic [2:0] cr, input logic [2:0] lr);
      return (32'(cbc) << lcfr_pkg::CBC_MODE_LSB) | (32'(thr) << lcfr_pkg::LOCK_THR_LSB)
         | (32'(md) << lcfr_pkg::LOCK_MODE_LSB) | (32'(deg) << lcfr_pkg::LOCK_DEG_LSB)
         | (32'(cr) << lcfr_pkg::CBC_RETRY_LSB) | (32'(lr) << lcfr_pkg::LOCK_RETRY_LSB);
   endfunction
   // one-cycle write strobe, read-back is due one edge later
   task automatic wr(input logic [31:0] w);
      cfgWrite = 1'b1;
      cfgWdata = w;
      tick(1);
      `CHK("cfgRdata", w, cfgRdata)
      cfgWrite = 1'b0;
      // a quiet edge keeps the strobe from being lowered and raised in one step
      tick(1);
   endtask
   // bounded wait for the fault output to reach a level; a timeout ends the run
   task automatic waitFault(input logic lvl, input int lim, output int cnt);
      cnt = 0;
      while (fault_out_n !== lvl && cnt < lim) begin
         tick(1);
         cnt++;
      end
      if (fault_out_n !== lvl) begin
         error_cnt++;
         $display("[ERR] fault_out_n wait expected %0b seen timeout", lvl);
         finish_test();
      end
   endtask
   // current removed first, otherwise the clear would be followed by a new lock
   task automatic clearFault;
      loadLevel = 8'h00;
      faultClear = 1'b1;
      tick(1);
      faultClear = 1'b0;
      tick(3);
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic test_reset;
      `CHK("cfgRdata", 32'h0000_0000, cfgRdata)
      `CHK("fault_out_n", 1'b1, fault_out_n)
      wr(32'hFFFF_FFFF);
      wr(32'h0000_0000);
      $display("test reset done");
   endtask
   task automatic test_latched;
      for (int m = 0; m < 4; m++) begin
         wr(cfg(4'h7, 4'h5, 4'(m), 4'h0, 3'h0, 3'h0));
         loadLevel = 8'h06;
         waitFault(1'b0, 20, n);
         `CHK("stageMode", expStage[m], stageMode)
         `CHK("highSideOn", (m == 2) ? 3'h7 : 3'h0, highSideOn)
         `CHK("lowSideOn", (m == 3) ? 3'h7 : 3'h0, lowSideOn)
         tick(50);
         `CHK("stageMode", expStage[m], stageMode)
         `CHK("fault_out_n", 1'b0, fault_out_n)
         clearFault();
         `CHK("fault_out_n", 1'b1, fault_out_n)
      end
      $display("test latched done");
   endtask
   task automatic test_retry;
      for (int m = 4; m < 8; m++) begin
         wr(cfg(4'h7, 4'h5, 4'(m), 4'h0, 3'h0, 3'(m - 4)));
         loadLevel = 8'h06;
         waitFault(1'b0, 20, n);
         `CHK("stageMode", expStage[m - 4], stageMode)
         `CHK("highSideOn", (m == 6) ? 3'h7 : 3'h0, highSideOn)
         `CHK("lowSideOn", (m == 7) ? 3'h7 : 3'h0, lowSideOn)
         loadLevel = 8'h00;
         waitFault(1'b1, 5000, n);
         `CHK("retry cycles", retryMs[m - 4] * 2, n)
         `CHK("stageMode", lcfr_pkg::STAGE_DRIVE, stageMode)
      end
      $display("test retry done");
   endtask
   task automatic test_report_off;
      wr(cfg(4'h7, 4'h5, 4'h8, 4'h0, 3'h0, 3'h0));
      loadLevel = 8'h06;
      tick(6);
      `CHK("lockReported", 1'b1, lockReported)
      `CHK("stageMode", lcfr_pkg::STAGE_DRIVE, stageMode)
      `CHK("fault_out_n", 1'b0, fault_out_n)
      clearFault();
      for (int m = 9; m < 17; m++) begin
         // the pass after code 15 keeps response 0 but sets the threshold code to 0
         wr(cfg(4'h7, (m == 16) ? 4'h0 : 4'h5, 4'(m), 4'h0, 3'h0, 3'h0));
         loadLevel = 8'h0F;
         tick(6);
         `CHK("lockReported", 1'b0, lockReported)
         `CHK("fault_out_n", 1'b1, fault_out_n)
      end
      wr(cfg(4'h7, 4'h5, 4'h0, 4'h0, 3'h0, 3'h0));
      loadLevel = 8'h05;
      tick(6);
      `CHK("fault_out_n", 1'b1, fault_out_n)
      clearFault();
      $display("test report and disable done");
   endtask
   task automatic test_filter;
      for (int d = 0; d < 3; d++) begin
         wr(cfg(4'h7, 4'h5, 4'h1, 4'(d), 3'h0, 3'h0));
         loadLevel = 8'h06;
         tick(degMs[d] * 2 - 1);
         loadLevel = 8'h00;
         tick(1);
         loadLevel = 8'h06;
         waitFault(1'b0, 40, n);
         `CHK("filter cycles", degMs[d] * 2 + 1, n)
         clearFault();
      end
      $display("test filter done");
   endtask
   task automatic test_cycle_limit;
      for (int c = 0; c < 5; c++) begin
         wr(cfg(cbcCode[c], 4'h0, 4'h9, 4'h0, 3'h2, 3'h0));
         n = 0;
         while (pwmCycleStart !== 1'b1 && n < 20) begin
            tick(1);
            n++;
         end
         if (pwmCycleStart !== 1'b1) begin
            error_cnt++;
            $display("[ERR] pwmCycleStart wait expected 1 seen timeout");
            finish_test();
         end
         hitReq = 1'b1;
         tick(1);
         hitReq = 1'b0;
         tick(2);
         `CHK("stageMode", (c == 4) ? lcfr_pkg::STAGE_DRIVE : expStage[1], stageMode)
         `CHK("fault_out_n", cbcFaultLvl[c], fault_out_n)
         p = 0;
         for (int k = 0; k < 100 && stageMode === lcfr_pkg::STAGE_RECIRC; k++) begin
            if (pwmCycleStart === 1'b1) p++;
            tick(1);
         end
         if (stageMode === lcfr_pkg::STAGE_RECIRC) begin
            error_cnt++;
            $display("[ERR] stageMode wait expected drive seen timeout");
            finish_test();
         end
         `CHK("pwm cycles", cbcStarts[c], p)
      end
      $display("test cycle limit done");
   endtask
   // a reset in mid-run must drop a latched brake and bring back the reset word
   task automatic test_reset_mid;
      wr(cfg(4'h7, 4'h5, 4'h2, 4'h0, 3'h0, 3'h0));
      loadLevel = 8'h06;
      waitFault(1'b0, 20, n);
      loadLevel = 8'h00;
      reset_n = 1'b0;
      tick(3);
      `CHK("fault_out_n", 1'b1, fault_out_n)
      `CHK("highSideOn", 3'h0, highSideOn)
      reset_n = 1'b1;
      tick(2);
      `CHK("stageMode", lcfr_pkg::STAGE_DRIVE, stageMode)
      `CHK("cfgRdata", 32'h0000_0000, cfgRdata)
      `CHK("fault_out_n", 1'b1, fault_out_n)
      $display("test mid-run reset done");
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      reset_n = 1'b0;
      cfgWrite = 1'b0;
      cfgWdata = 32'h0000_0000;
      hitReq = 1'b0;
      faultClear = 1'b0;
      loadLevel = 8'h00;
      tick(3);
      reset_n = 1'b1;
      test_reset();
      test_filter();
      test_latched();
      test_retry();
      test_report_off();
      test_cycle_limit();
      test_reset_mid();
      finish_test();
   end
endmodule // lcfr_lock_current_fault_response_bench
`default_nettype wire
